// ---- cpu_model.sv ----
`timescale 1ns/10ps
// Core stand-in: clear and halt instructions, sleep state
module cpu_model #(parameter int KICK = 2000)
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Bench requests, watchdog events
    input  wire logic kick_en,
    input  wire logic halt_req,
    input  wire logic wake,
    input  wire logic device_reset,
    // Instructions, core state
    output logic      clear_watchdog_instruction,
    output logic      halt_instruction,
    output logic      sleep_mode
);
    int cnt; // Cycles since last wrap at KICK; a clear goes out at each wrap only when kick_en is set and awake
    // Asleep the core runs no code, so never clears then
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            clear_watchdog_instruction <= 1'b0;
            halt_instruction <= 1'b0;
            sleep_mode <= 1'b0;
        end
        else
        begin
            cnt <= (cnt >= KICK) ? 0 : cnt + 1;
            clear_watchdog_instruction <= kick_en && !sleep_mode && cnt == KICK;
            halt_instruction <= halt_req;
            sleep_mode <= halt_req || (sleep_mode && !wake && !device_reset);
        end
    end
endmodule : cpu_model

// ---- slow_tick_sync.sv ----
`timescale 1ns/10ps
module slow_tick_sync
    import wdg_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Oscillator pin
    input  wire logic slow_clock,
    // One pclk pulse per slow rising edge
    output logic      tick
);

    logic [2:0] sync;   // Three-flop chain
    logic       level;  // Last agreed level

    ////////////////////////////////////////////////////////////////////////
    // Chain; only the second and third stages are compared
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync  <= 3'h0;
            level <= 1'b0;
            tick  <= 1'b0;
        end
        else
        begin
            sync <= {sync[1:0], slow_clock};
            tick <= 1'b0;
            // A change counts once two later stages agree [R01]
            if (sync[1] == sync[2] && sync[2] != level)
            begin
                level <= sync[2];
                tick  <= sync[2];
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TICK_PULSE: assert property (tick |=> !tick) // [R01]
        else $error("slow tick longer than one cycle");

endmodule : slow_tick_sync

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    import wdg_pkg::*;
    localparam int SP = 20; // Pclk cycles per slow period
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 0, v;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, slow_clock = 0, kick_en = 0, halt_req = 0;
    logic undervoltage_event = 0, voltage_select_event = 0, device_reset, wake;
    logic clear_watchdog_instruction, halt_instruction, sleep_mode, pc_sp_clear;
    logic port_init, timeout_status_flag, power_down_flag;
    int n_mismatch = 0, checks_done = 0, n_rst = 0, n_wake = 0, n, b;
    int n_pcsp = 0, n_port = 0; // Negedges with pc_sp_clear / port_init high
    always #50 pclk = ~pclk;
    always #1000 slow_clock = ~slow_clock;
    // Count reset and wake pulses away from the sampling edge
    always @(negedge pclk)
    begin
        n_rst += device_reset;
        n_wake += wake;
        n_pcsp += pc_sp_clear;
        n_port += port_init;
    end
    wdg_top #(.SOFT_RESET_TICKS(8'h01)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .slow_clock,
        .clear_watchdog_instruction, .halt_instruction, .sleep_mode, .undervoltage_event,
        .voltage_select_event, .device_reset, .pc_sp_clear, .port_init, .wake,
        .timeout_status_flag, .power_down_flag);
    cpu_model #(.KICK(2000)) cpu (.pclk, .presetn, .kick_en, .halt_req, .wake,
        .device_reset, .clear_watchdog_instruction, .halt_instruction, .sleep_mode);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Bounded wait for a reset or wake pulse
    task wait_ev(input int lim);
        b = n_rst + n_wake;
        n = 0;
        while (n_rst + n_wake == b && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_ev
    function automatic int ticks(input int s);
        return 1 << (s < 4 ? 8 + 2 * s : s + 11);
    endfunction : ticks
    task final_report;
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    initial
    begin
        void'($urandom(32'hdc03));
        repeat (3) @(posedge pclk);
        chk(port_init & pc_sp_clear, 1);
        presetn <= 1;
        apb(0, ADDR_CONTROL, 0);
        chk(r, CONTROL_POR);
        apb(0, ADDR_GUARD, 0);
        chk(r, GUARD_POR);
        apb(0, ADDR_FLAGS, 0);
        chk(r & 32'hFFFF_FFFB, 0);
        apb(0, 8'h10, 0);
        chk(err, 1);
        v = 8'($urandom);
        apb(1, ADDR_CONTROL, {KEY_ENABLE, v[2:0]});
        apb(0, ADDR_CONTROL, 0);
        chk(r, {KEY_ENABLE, v[2:0]});
        // Periodic clears hold off a 2^8 period, then stop
        apb(1, ADDR_CONTROL, {KEY_ENABLE, 3'b000});
        kick_en <= 1;
        wait_ev(15000);
        chk(n, 15000);
        kick_en <= 0;
        wait_ev(ticks(0) * SP + 2100);
        chk(n_rst, 1);
        apb(0, ADDR_STATUS, 0);
        chk(r[STAT_TO], 1);
        // Halt clears the count; overflow asleep only wakes
        for (int s = 0; s < 2; s++)
        begin
            apb(1, ADDR_CONTROL, {KEY_ENABLE, 3'(s)});
            halt_req <= 1;
            @(posedge pclk);
            halt_req <= 0;
            wait_ev(ticks(s) * SP + 50);
            chk(n > (ticks(s) - 1) * SP && n <= ticks(s) * SP + 12, 1);
            chk(n_wake, s + 1);
            chk(n_rst, 1);
            apb(0, ADDR_STATUS, 0);
            chk(r[1:0], 2'b11);
            chk({timeout_status_flag, power_down_flag}, 2'b11);
        end
        do v = 8'($urandom); while (v[7:3] == KEY_ENABLE || v[7:3] == KEY_DISABLE);
        apb(1, ADDR_CONTROL, v);
        wait_ev(5 * SP);
        chk(n_rst, 2);
        apb(1, ADDR_FLAGS, 8'h01);
        apb(0, ADDR_FLAGS, 0);
        chk(r[FLAG_KEY], 1);
        apb(1, ADDR_FLAGS, 8'h00);
        apb(0, ADDR_FLAGS, 0);
        chk(r[FLAG_KEY], 0);
        do v = 8'($urandom); while (v == GUARD_OK_A || v == GUARD_OK_B);
        apb(1, ADDR_GUARD, v);
        wait_ev(5 * SP);
        apb(0, ADDR_FLAGS, 0);
        chk(n_rst, 3);
        chk(r[FLAG_GUARD], 1);
        apb(1, ADDR_CONTROL, {KEY_DISABLE, 3'b000});
        wait_ev(ticks(0) * SP + 1000);
        chk(n, ticks(0) * SP + 1000);
        // Every full reset and sleep overflow clears PC; three reset negedges
        chk(n_pcsp, n_port + n_wake);
        chk(n_port, n_rst + 3);
        final_report;
    end
    // Hang guard, well past the expected run
    initial
    begin
        #8_000_000;
        n_mismatch++;
        final_report;
    end
endmodule : testbench

// ---- wdg_pkg.sv ----
package wdg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map: byte offsets on the APB, one aligned word each
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS   = 8'h04;
    localparam logic [7:0] ADDR_GUARD   = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0C;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and legal codes
    localparam logic [7:0] CONTROL_POR = 8'h53;
    localparam logic [7:0] GUARD_POR   = 8'h55;
    localparam logic [7:0] GUARD_OK_A  = 8'h55;
    localparam logic [7:0] GUARD_OK_B  = 8'hAA;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [4:0] KEY_ENABLE  = 5'h0A;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in the flag and status registers
    localparam int FLAG_KEY   = 0;
    localparam int FLAG_VSEL  = 1;
    localparam int FLAG_UNDER = 2;
    localparam int FLAG_GUARD = 3;
    localparam int FLAG_BITS  = 4;
    localparam int STAT_TO    = 0;
    localparam int STAT_PDF   = 1;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int         SLOW_CLOCK_HZ          = 32000;
    localparam logic [7:0] SOFT_RESET_SLOW_CYCLES = 8'h04;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [4:0] key;
        logic [2:0] sel;
    } wdt_ctrl_s;

    typedef enum logic [1:0] {
        SR_IDLE = 2'b00,
        SR_WAIT = 2'b01,
        SR_FIRE = 2'b10
    } soft_state_e;

endpackage : wdg_pkg

// ---- wdg_top.sv ----
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// What this block does
// R01: Counter runs from slow RC oscillator ticks
// R02: Select codes 0..6 give 2^8..2^17
// R03: Select code 7 gives 2^18
// R04: Key 10101B disables, 01010B enables
// R05: Other key: delayed reset, key flag set
// R06: Key field starts at 01010B
// R07: Overflow when awake: full reset, timeout flag
// R08: Overflow asleep: timeout flag, clear PC/SP only
// R09: Count cleared by key reset, clear, halt
// R10: Software issues clear before period ends
// R11: Key flag sticky; only software zero clears
// R12: Guard legal values idle; others delayed reset
// R13: Guard starts at 01010101B
// R14: Guard reset sets guard flag, software clears
// R15: Flag register upper four bits read zero
// R16: Power-on clears PC, ports become inputs
// R17: Key bits 7..3, select bits 2..0, RW
// R18: Halt clears count, sets power-down, clears timeout
// R19: Overflow asleep wakes device, sets timeout
// R20: Soft-reset delay is configurable slow ticks
module wdg_top
    import wdg_pkg::*;
#(
    parameter logic [7:0] SOFT_RESET_TICKS = SOFT_RESET_SLOW_CYCLES
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Slow oscillator pin
    input  wire logic        slow_clock,
    // CPU core, same clock
    input  wire logic        clear_watchdog_instruction,
    input  wire logic        halt_instruction,
    input  wire logic        sleep_mode,
    // Other reset sources, same clock
    input  wire logic        undervoltage_event,
    input  wire logic        voltage_select_event,
    // Reset and wake outputs
    output logic             device_reset,
    output logic             pc_sp_clear,
    output logic             port_init,
    output logic             wake,
    // Status flags
    output logic             timeout_status_flag,
    output logic             power_down_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    wdt_ctrl_s              watchdog_control;   // Key and period
    logic [7:0]             reset_guard;        // Guard byte
    logic [FLAG_BITS-1:0]   reset_cause_flags;  // Sticky causes
    logic [FLAG_BITS-1:0]   flag_set;           // Hardware set terms
    logic [FLAG_BITS-1:0]   flag_clr;           // Software clear terms
    soft_state_e            sr_state;           // Soft-reset sequencer
    logic [7:0]             delay_cnt;          // Slow ticks waited
    logic                   key_bad;            // Latched key fault
    logic                   guard_bad;          // Latched guard fault
    logic                   key_bad_now;        // Key not legal
    logic                   guard_bad_now;      // Guard not legal
    logic                   fire;               // Soft reset this cycle
    logic                   full_rst;           // Any full device reset
    logic                   sleep_ovf;          // Overflow while asleep
    logic                   slow_tick;          // Synced slow edge
    logic                   overflow;           // Counter expired
    logic [17:0]            wdt_count;          // Counter value
    logic                   wdt_enable;         // Key says run
    logic                   wdt_clear;          // Counter clear
    logic                   setup;              // APB setup phase
    logic                   access;             // APB completing edge
    logic                   wr_ctrl;            // Control write
    logic                   wr_guard;           // Guard write
    logic                   wr_flags;           // Flag write

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // True for the four mapped words
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ADDR_CONTROL) || (a == ADDR_FLAGS) ||
                    (a == ADDR_GUARD) || (a == ADDR_STATUS);
    endfunction : is_mapped

    // Read view of one register
    function automatic logic [7:0] read_byte(input logic [7:0] a);
        case (a)
            ADDR_CONTROL: read_byte = watchdog_control;             // [R17]
            ADDR_FLAGS:   read_byte = {4'h0, reset_cause_flags};    // [R15]
            ADDR_GUARD:   read_byte = reset_guard;
            ADDR_STATUS:  read_byte = {6'h00, power_down_flag,
                                       timeout_status_flag};
            default:      read_byte = 8'h00;
        endcase
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////////
    // Combinational terms

    // Zero wait states: pready rises in the first access cycle
    assign setup    = psel && !penable;
    assign access   = psel && penable && pready;
    assign wr_ctrl  = access && pwrite && (paddr == ADDR_CONTROL);
    assign wr_guard = access && pwrite && (paddr == ADDR_GUARD);
    assign wr_flags = access && pwrite && (paddr == ADDR_FLAGS);

    // Legal key codes; anything else starts a soft reset
    assign key_bad_now = (watchdog_control.key != KEY_ENABLE) &&
                         (watchdog_control.key != KEY_DISABLE);       // [R05]
    // Legal guard codes; anything else starts a soft reset
    assign guard_bad_now = (reset_guard != GUARD_OK_A) &&
                           (reset_guard != GUARD_OK_B);               // [R12]

    assign wdt_enable = (watchdog_control.key == KEY_ENABLE);         // [R04]
    assign fire       = (sr_state == SR_FIRE);
    // Awake overflow is a full reset; asleep only PC and SP
    assign full_rst   = fire || (overflow && !sleep_mode);           // [R07]
    assign sleep_ovf  = overflow && sleep_mode;                      // [R08]
    // Software keeps the count below the period with clear [R10]
    assign wdt_clear  = clear_watchdog_instruction || halt_instruction ||
                        fire;                                        // [R09]

    // Hardware set terms per flag bit
    assign flag_set[FLAG_KEY]   = fire && key_bad;                   // [R11]
    assign flag_set[FLAG_VSEL]  = voltage_select_event;
    assign flag_set[FLAG_UNDER] = undervoltage_event;
    assign flag_set[FLAG_GUARD] = fire && guard_bad;                 // [R14]
    // Writing zero clears a bit; writing one does nothing
    assign flag_clr = wr_flags ? ~pwdata[FLAG_BITS-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    // Slow oscillator comes from another domain
    slow_tick_sync u_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .slow_clock (slow_clock),
        .tick       (slow_tick)
    );

    // Period counter
    wdt_counter u_counter (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (slow_tick),
        .enable   (wdt_enable),
        .clear    (wdt_clear),
        .sel      (watchdog_control.sel),
        .count    (wdt_count),
        .overflow (overflow)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB answer: data and error captured in setup, shown in access

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !is_mapped(paddr);
            // Read data only for reads; zero otherwise
            if (setup && !pwrite)
            begin
                prdata <= {24'h00_0000, read_byte(paddr)};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; a full reset reloads it so a bad key cannot loop

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watchdog_control <= CONTROL_POR;                          // [R06]
        end
        else if (full_rst)
        begin
            watchdog_control <= CONTROL_POR;
        end
        else if (wr_ctrl)
        begin
            watchdog_control <= wdt_ctrl_s'(pwdata[7:0]);             // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Guard register

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_guard <= GUARD_POR;                                 // [R13]
        end
        else if (full_rst)
        begin
            reset_guard <= GUARD_POR;
        end
        else if (wr_guard)
        begin
            reset_guard <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cause flags: set wins over clear; a device reset leaves them

    for (genvar i = 0; i < FLAG_BITS; i++)
    begin : g_flag
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                reset_cause_flags[i] <= 1'b0;
            end
            else if (flag_set[i])
            begin
                reset_cause_flags[i] <= 1'b1;                         // [R11]
            end
            else if (flag_clr[i])
            begin
                reset_cause_flags[i] <= 1'b0;                         // [R14]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft-reset sequencer: once a bad value is seen the reset is
    // committed; fixing the value during the wait does not cancel it

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sr_state  <= SR_IDLE;
            delay_cnt <= 8'h00;
            key_bad   <= 1'b0;
            guard_bad <= 1'b0;
        end
        else
        begin
            case (sr_state)
                SR_IDLE:
                begin
                    delay_cnt <= 8'h00;
                    key_bad   <= key_bad_now;
                    guard_bad <= guard_bad_now;
                    // Overflow reset reloads the registers first
                    if ((key_bad_now || guard_bad_now) && !full_rst)
                    begin
                        sr_state <= SR_WAIT;                          // [R05]
                    end
                end
                SR_WAIT:
                begin
                    // Collect a second fault seen during the wait
                    key_bad   <= key_bad || key_bad_now;
                    guard_bad <= guard_bad || guard_bad_now;
                    if (overflow && !sleep_mode)
                    begin
                        sr_state <= SR_IDLE;
                    end
                    else if (slow_tick)
                    begin
                        // Zero ticks behaves as one
                        if (delay_cnt + 8'h01 >= SOFT_RESET_TICKS)
                        begin
                            sr_state <= SR_FIRE;                      // [R20]
                        end
                        else
                        begin
                            delay_cnt <= delay_cnt + 8'h01;
                        end
                    end
                end
                SR_FIRE:
                begin
                    sr_state <= SR_IDLE;
                end
                default:
                begin
                    sr_state <= SR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timeout and power-down flags

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timeout_status_flag <= 1'b0;
            power_down_flag     <= 1'b0;
        end
        else
        begin
            // Overflow wins over a halt in the same cycle
            if (overflow)
            begin
                timeout_status_flag <= 1'b1;                          // [R19]
            end
            else if (halt_instruction)
            begin
                timeout_status_flag <= 1'b0;                          // [R18]
            end
            // Halt wins over a clear in the same cycle
            if (halt_instruction)
            begin
                power_down_flag <= 1'b1;                              // [R18]
            end
            else if (clear_watchdog_instruction)
            begin
                power_down_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset and wake outputs, one cycle each; PC and ports held at POR

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            device_reset <= 1'b0;
            pc_sp_clear  <= 1'b1;                                     // [R16]
            port_init    <= 1'b1;                                     // [R16]
            wake         <= 1'b0;
        end
        else
        begin
            device_reset <= full_rst;                                 // [R07]
            pc_sp_clear  <= full_rst || sleep_ovf;                    // [R08]
            port_init    <= full_rst;
            wake         <= sleep_ovf;                                // [R19]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_AWAKE_OVF: assert property (overflow && !sleep_mode |=> device_reset && timeout_status_flag) // [R07]
        else $error("awake overflow gave no full reset");
    AST_SLEEP_OVF: assert property (sleep_ovf |=> pc_sp_clear && wake && !device_reset && timeout_status_flag) // [R08]
        else $error("sleep overflow handled wrongly");
    AST_KEY_RESET: assert property (fire && key_bad |=> device_reset && reset_cause_flags[FLAG_KEY] && wdt_count == 18'h0_0000) // [R05]
        else $error("key reset missing effects");
    AST_GUARD_RESET: assert property (fire && guard_bad |=> device_reset && reset_cause_flags[FLAG_GUARD]) // [R14]
        else $error("guard reset missing effects");
    AST_KEY_STICKY: assert property (reset_cause_flags[FLAG_KEY] && !(wr_flags && !pwdata[FLAG_KEY]) |=> reset_cause_flags[FLAG_KEY]) // [R11]
        else $error("key flag dropped without software");
    AST_UPPER_ZERO: assert property (setup && !pwrite && paddr == ADDR_FLAGS |=> prdata[31:4] == 28'h000_0000) // [R15]
        else $error("flag register upper bits not zero");
    AST_HALT_FLAGS: assert property (halt_instruction && !overflow |=> power_down_flag && !timeout_status_flag) // [R18]
        else $error("halt flags wrong");
    AST_LEGAL_QUIET: assert property (sr_state == SR_IDLE && !key_bad_now && !guard_bad_now && !overflow |=> !device_reset) // [R12]
        else $error("reset with legal values");
    AST_DELAY_WAIT: assert property (sr_state == SR_IDLE && $past(sr_state) == SR_IDLE && (key_bad_now || guard_bad_now) && !full_rst |=> sr_state == SR_WAIT ##1 !device_reset) // [R20]
        else $error("soft reset not delayed");

    COV_SLEEP_WAKE: cover property (sleep_ovf ##1 wake);
    COV_KEY_FIRE:   cover property (fire && key_bad);
    COV_GUARD_FIRE: cover property (fire && guard_bad);
    COV_AWAKE_OVF:  cover property (overflow && !sleep_mode);

endmodule : wdg_top

// ---- wdt_counter.sv ----
`timescale 1ns/10ps
module wdt_counter
    import wdg_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control
    input  wire logic        tick,
    input  wire logic        enable,
    input  wire logic        clear,
    input  wire logic [2:0]  sel,
    // State
    output logic      [17:0] count,
    output logic             overflow
);

    ////////////////////////////////////////////////////////////////////////
    // Last count before overflow for each period code
    function automatic logic [17:0] limit_of(input logic [2:0] code);
        case (code)
            3'h0:    limit_of = 18'h0_00FF;  // [R02]
            3'h1:    limit_of = 18'h0_03FF;
            3'h2:    limit_of = 18'h0_0FFF;
            3'h3:    limit_of = 18'h0_3FFF;
            3'h4:    limit_of = 18'h0_7FFF;
            3'h5:    limit_of = 18'h0_FFFF;
            3'h6:    limit_of = 18'h1_FFFF;
            default: limit_of = 18'h3_FFFF;  // [R03]
        endcase
    endfunction : limit_of

    logic at_limit;  // Count has reached the period
    // Compare with >= so a shorter period chosen mid-count still expires
    assign at_limit = (count >= limit_of(sel));

    ////////////////////////////////////////////////////////////////////////
    // Counter on slow ticks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count    <= 18'h0_0000;
            overflow <= 1'b0;
        end
        else
        begin
            overflow <= 1'b0;
            if (clear)
            begin
                count <= 18'h0_0000;  // [R09]
            end
            else if (enable && tick)
            begin
                if (at_limit)
                begin
                    count    <= 18'h0_0000;
                    overflow <= 1'b1;  // [R01]
                end
                else
                begin
                    count <= count + 18'h0_0001;
                end
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CLEAR_ZERO: assert property (clear |=> count == 18'h0_0000) // [R09]
        else $error("count not zero after clear");
    AST_HOLD_DISABLED: assert property (!enable && !clear |=> $stable(count)) // [R04]
        else $error("disabled counter moved");
    AST_OVF_AT_LIMIT: assert property (overflow |-> $past(count) >= $past(limit_of(sel))) // [R02]
        else $error("overflow before period");

endmodule : wdt_counter
